// [sbs_cfg.svh]
// Constants of the byte serdes with line and clock diagnostics
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_ADDR_CTRL 12'h000
`define SBS_ADDR_STATUS 12'h004
`define SBS_ADDR_RXBYTE 12'h008
`define SBS_CTRL_RESET 8'h04
`define SBS_SILENCE_BITS 8'd128
`define SBS_REF_WIN 6'd16
`define SBS_LOCK_WIN 20000
`define SBS_LOSE_PPM 500
`define SBS_GAIN_PPM 100
`define SBS_A1_BYTE 8'hf6
`define SBS_A2_BYTE 8'h28
`define SBS_A1_HIGH_RATE 4'd12
`define SBS_A1_LOW_RATE 4'd3
`define SBS_A2_NEED 2'd3
`define SBS_BYPASS_DIV 2'd3
`define SBS_DIV_19M 6'd32
`define SBS_DIV_38M 6'd16
`define SBS_DIV_51M 6'd12
`define SBS_DIV_77M 6'd8
`define SBS_DIV_155M 6'd4
`endif

// [sbs_far_end.sv]
// Far side model: reference oscillator and optics line
`timescale 1ns/1ps
module sbs_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_run,
  input wire logic line_run,
  input wire logic [7:0] line_byte,
  output logic synth_ref_clock,
  output logic rx_line_clock,
  output logic rx_serial_bit,
  output logic byte_taken
);
  logic [2:0] idx_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_ref_clock <= 1'b0;
      rx_line_clock <= 1'b0;
      rx_serial_bit <= 1'b0;
      byte_taken <= 1'b0;
      idx_q <= 3'd7;
    end else begin
      byte_taken <= 1'b0;
      // Reference stops only when a test asks for it
      if (ref_run) begin
        synth_ref_clock <= ~synth_ref_clock;
      end
      // Line clock stands still while the optics are idle
      if (line_run) begin
        rx_line_clock <= ~rx_line_clock;
        // Bit changes on the falling edge, MSB first, steady at the rise
        if (rx_line_clock) begin
          rx_serial_bit <= line_byte[idx_q];
          idx_q <= idx_q - 3'd1;
          byte_taken <= (idx_q == 3'd0);
        end
      end
    end
  end
endmodule // sbs_far_end

// [sbs_pkg.sv]
// Types of the byte serdes with line and clock diagnostics
package sbs_pkg;
  typedef struct packed {
    logic bypass;
    logic [2:0] ref_sel;
    logic slave_mode;
    logic rx_bus_oe;
    logic ref_tx_mode;
    logic spare;
  } sbs_ctrl_type;
  typedef enum logic [1:0] {FRM_IDLE, FRM_A1, FRM_A2} sbs_frm_type;
endpackage

// [sbs_serdes.sv]
// Byte mux and demux with framer and line and clock diagnostics
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_serdes import sbs_pkg::*; #(
  parameter int LOCK_WIN = `SBS_LOCK_WIN,
  parameter int RX_PER_REF = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_reset_n,
  input wire logic synth_ref_clock,
  input wire logic rx_line_clock,
  input wire logic rx_serial_bit,
  input wire logic line_signal_lost_n,
  input wire logic transition_alarm_clear,
  input wire logic reframe_request,
  input wire logic low_rate_select,
  input wire logic tx_clk_phase_sel_lo,
  input wire logic tx_clk_phase_sel_hi,
  input wire logic [7:0] tx_parallel_bytes,
  output logic tx_byte_clock,
  output logic tx_serial_bit,
  output logic [7:0] rx_parallel_bytes,
  output logic rx_bus_oe,
  output logic rx_byte_clock,
  output logic frame_found_pulse,
  output logic ref_clock_missing,
  output logic no_transition_alarm,
  output logic rx_freq_locked,
  output logic cdr_tracks_ref
);
  localparam int LOSE_DEV = LOCK_WIN * `SBS_LOSE_PPM / 1000000;
  localparam int GAIN_DEV = LOCK_WIN * `SBS_GAIN_PPM / 1000000;
  localparam int EXPECT = LOCK_WIN * RX_PER_REF;

  sbs_ctrl_type ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic ref_prev_q, rxc_prev_q, ref_edge, rx_edge, lost, cnt_clr;
  logic [5:0] ref_gap_q, ref_gap_d;
  logic ref_missing_q, ref_missing_d;
  logic [1:0] pre_q, pre_d;
  logic tx_tick;
  logic [2:0] tx_cnt_q, tx_cnt_d;
  logic [7:0] tx_shift_q, tx_shift_d, ref_byte_q, ref_byte_d;
  logic tx_bit_q, tx_bit_d, tx_bc_q, tx_bc_d;
  logic rx_tick, rx_bit;
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_shift_q, rx_shift_d, rx_byte_q, rx_byte_d;
  logic rx_bc_q, rx_bc_d;
  sbs_frm_type frm_q, frm_d;
  logic [2:0] frm_pos_q, frm_pos_d;
  logic [3:0] a1_cnt_q, a1_cnt_d, a1_need;
  logic [1:0] a2_cnt_q, a2_cnt_d;
  logic sync_q, sync_d, realign;
  logic line_prev_q, line_prev_d, alarm_q, alarm_d;
  logic [7:0] quiet_q, quiet_d;
  logic [31:0] win_ref_q, win_ref_d, win_rx_q, win_rx_d;
  logic locked_q, locked_d;
  logic [5:0] synth_div;
  logic synth_halve;

  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != `SBS_ADDR_CTRL && paddr != `SBS_ADDR_STATUS
                   && paddr != `SBS_ADDR_RXBYTE;
  assign prdata = prdata_q;
  assign ref_edge = synth_ref_clock && !ref_prev_q;
  assign rx_edge = rx_line_clock && !rxc_prev_q;
  assign lost = !line_signal_lost_n;
  assign cnt_clr = !counter_reset_n;

  // Reference divider choice for the transmit synthesizer
  always_comb begin
    synth_halve = 1'b0;
    case (ctrl_q.ref_sel)
      3'd0: synth_div = `SBS_DIV_19M;
      3'd1: synth_div = `SBS_DIV_38M;
      3'd2: synth_div = `SBS_DIV_51M;
      3'd3: synth_div = `SBS_DIV_77M;
      3'd4: begin
        synth_div = `SBS_DIV_155M;
        synth_halve = 1'b1;
      end
      default: synth_div = `SBS_DIV_77M;
    endcase
  end

  // Register file
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    if (psel && !penable) begin
      case (paddr)
        `SBS_ADDR_CTRL: prdata_d = {24'h0, ctrl_q};
        `SBS_ADDR_STATUS: prdata_d = {17'h0, synth_halve, synth_div, 2'h0, cdr_tracks_ref, lost,
                                      rx_freq_locked, no_transition_alarm, ref_clock_missing,
                                      frame_found_pulse};
        `SBS_ADDR_RXBYTE: prdata_d = {24'h0, rx_byte_q};
        default: prdata_d = 32'h0;
      endcase
    end
    if (psel && penable && pwrite && paddr == `SBS_ADDR_CTRL) ctrl_d = sbs_ctrl_type'(pwdata[7:0]);
  end

  // Reference watchdog, counted on pclk
  always_comb begin
    ref_gap_d = (ref_edge || cnt_clr) ? 6'h0 : (ref_gap_q == `SBS_REF_WIN ? ref_gap_q : ref_gap_q + 6'h1);
    ref_missing_d = ref_edge ? 1'b0 : (ref_gap_q == `SBS_REF_WIN);
  end

  // Transmit side: bit tick, byte counter, phased byte clock, shifter
  always_comb begin
    pre_d = (pre_q == `SBS_BYPASS_DIV || cnt_clr) ? 2'h0 : pre_q + 2'h1;
    tx_tick = (ctrl_q.bypass && low_rate_select) ? (pre_q == `SBS_BYPASS_DIV) : 1'b1;
    tx_cnt_d = cnt_clr ? 3'h0 : (tx_tick ? tx_cnt_q + 3'h1 : tx_cnt_q);
    tx_bc_d = 3'(tx_cnt_d - {tx_clk_phase_sel_hi, tx_clk_phase_sel_lo, 1'b0}) < 3'd4;
    ref_byte_d = ref_edge ? tx_parallel_bytes : ref_byte_q;
    tx_shift_d = tx_shift_q;
    tx_bit_d = tx_bit_q;
    if (tx_tick) begin
      tx_bit_d = tx_shift_q[7];
      if (tx_cnt_q == 3'd7) tx_shift_d = ctrl_q.ref_tx_mode ? ref_byte_q : tx_parallel_bytes;
      else tx_shift_d = {tx_shift_q[6:0], 1'b0};
    end
  end

  // Receive side: bit source, deserializer, byte clock, squelch
  always_comb begin
    rx_tick = lost ? tx_tick : rx_edge;
    rx_bit = lost ? 1'b0 : rx_serial_bit;
    rx_shift_d = rx_tick ? {rx_shift_q[6:0], rx_bit} : rx_shift_q;
    rx_cnt_d = rx_cnt_q;
    rx_byte_d = rx_byte_q;
    if (cnt_clr || (rx_tick && realign)) rx_cnt_d = 3'h0;
    else if (rx_tick) rx_cnt_d = rx_cnt_q + 3'h1;
    if (rx_tick && (rx_cnt_q == 3'd7 || realign)) rx_byte_d = rx_shift_d;
    if (lost) rx_byte_d = 8'h0;
    rx_bc_d = rx_cnt_d < 3'd4;
  end

  // Framer over the receive bit window
  always_comb begin
    a1_need = low_rate_select ? `SBS_A1_LOW_RATE : `SBS_A1_HIGH_RATE;
    frm_d = frm_q;
    frm_pos_d = frm_pos_q;
    a1_cnt_d = a1_cnt_q;
    a2_cnt_d = a2_cnt_q;
    sync_d = 1'b0;
    realign = 1'b0;
    if (cnt_clr) begin
      frm_d = FRM_IDLE;
    end else if (rx_tick) begin
      frm_pos_d = frm_pos_q + 3'h1;
      case (frm_q)
        FRM_IDLE: begin
          if (rx_shift_d == `SBS_A1_BYTE) begin
            frm_d = FRM_A1;
            frm_pos_d = 3'h0;
            a1_cnt_d = 4'h1;
          end
        end
        FRM_A1: begin
          if (frm_pos_q == 3'd7) begin
            if (rx_shift_d == `SBS_A1_BYTE) begin
              a1_cnt_d = (a1_cnt_q == 4'hf) ? a1_cnt_q : a1_cnt_q + 4'h1;
            end else if (rx_shift_d == `SBS_A2_BYTE && a1_cnt_q >= a1_need) begin
              frm_d = FRM_A2;
              a2_cnt_d = 2'h1;
            end else begin
              frm_d = FRM_IDLE;
            end
          end
        end
        FRM_A2: begin
          if (frm_pos_q == 3'd7) begin
            if (rx_shift_d != `SBS_A2_BYTE) begin
              frm_d = FRM_IDLE;
            end else if (a2_cnt_q + 2'h1 == `SBS_A2_NEED) begin
              frm_d = FRM_IDLE;
              sync_d = 1'b1;
              realign = reframe_request;
            end else begin
              a2_cnt_d = a2_cnt_q + 2'h1;
            end
          end
        end
        default: frm_d = FRM_IDLE;
      endcase
    end
  end

  // Silence alarm and frequency lock
  always_comb begin
    line_prev_d = rx_edge ? rx_serial_bit : line_prev_q;
    quiet_d = quiet_q;
    alarm_d = alarm_q;
    if (cnt_clr || transition_alarm_clear || (rx_edge && rx_serial_bit != line_prev_q)) quiet_d = 8'h0;
    else if (rx_edge && quiet_q != `SBS_SILENCE_BITS) quiet_d = quiet_q + 8'h1;
    if (quiet_d == `SBS_SILENCE_BITS) alarm_d = 1'b1;
    if (transition_alarm_clear) alarm_d = 1'b0;
    win_ref_d = win_ref_q;
    win_rx_d = rx_edge ? win_rx_q + 32'h1 : win_rx_q;
    locked_d = locked_q;
    if (cnt_clr) begin
      win_ref_d = 32'h0;
      win_rx_d = 32'h0;
    end else if (ref_edge) begin
      if (win_ref_q == 32'(LOCK_WIN - 1)) begin
        if (locked_q && (win_rx_d > 32'(EXPECT + LOSE_DEV) || win_rx_d < 32'(EXPECT - LOSE_DEV)))
          locked_d = 1'b0;
        if (!locked_q && win_rx_d <= 32'(EXPECT + GAIN_DEV) && win_rx_d >= 32'(EXPECT - GAIN_DEV))
          locked_d = 1'b1;
        win_ref_d = 32'h0;
        win_rx_d = 32'h0;
      end else begin
        win_ref_d = win_ref_q + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sbs_ctrl_type'(`SBS_CTRL_RESET);
      prdata_q <= 32'h0;
      ref_prev_q <= 1'b0;
      rxc_prev_q <= 1'b0;
      ref_gap_q <= 6'h0;
      ref_missing_q <= 1'b0;
      pre_q <= 2'h0;
      tx_cnt_q <= 3'h0;
      tx_shift_q <= 8'h0;
      ref_byte_q <= 8'h0;
      tx_bit_q <= 1'b0;
      tx_bc_q <= 1'b0;
      rx_cnt_q <= 3'h0;
      rx_shift_q <= 8'h0;
      rx_byte_q <= 8'h0;
      rx_bc_q <= 1'b0;
      frm_q <= FRM_IDLE;
      frm_pos_q <= 3'h0;
      a1_cnt_q <= 4'h0;
      a2_cnt_q <= 2'h0;
      sync_q <= 1'b0;
      line_prev_q <= 1'b0;
      quiet_q <= 8'h0;
      alarm_q <= 1'b0;
      win_ref_q <= 32'h0;
      win_rx_q <= 32'h0;
      locked_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      ref_prev_q <= synth_ref_clock;
      rxc_prev_q <= rx_line_clock;
      ref_gap_q <= ref_gap_d;
      ref_missing_q <= ref_missing_d;
      pre_q <= pre_d;
      tx_cnt_q <= tx_cnt_d;
      tx_shift_q <= tx_shift_d;
      ref_byte_q <= ref_byte_d;
      tx_bit_q <= tx_bit_d;
      tx_bc_q <= tx_bc_d;
      rx_cnt_q <= rx_cnt_d;
      rx_shift_q <= rx_shift_d;
      rx_byte_q <= rx_byte_d;
      rx_bc_q <= rx_bc_d;
      frm_q <= frm_d;
      frm_pos_q <= frm_pos_d;
      a1_cnt_q <= a1_cnt_d;
      a2_cnt_q <= a2_cnt_d;
      sync_q <= sync_d;
      line_prev_q <= line_prev_d;
      quiet_q <= quiet_d;
      alarm_q <= alarm_d;
      win_ref_q <= win_ref_d;
      win_rx_q <= win_rx_d;
      locked_q <= locked_d;
    end
  end

  assign tx_byte_clock = tx_bc_q;
  assign tx_serial_bit = tx_bit_q;
  assign rx_parallel_bytes = rx_byte_q;
  assign rx_bus_oe = ctrl_q.rx_bus_oe;
  assign rx_byte_clock = rx_bc_q;
  assign frame_found_pulse = sync_q;
  assign ref_clock_missing = ref_missing_q;
  assign no_transition_alarm = alarm_q;
  assign rx_freq_locked = locked_q;
  assign cdr_tracks_ref = lost && !ctrl_q.slave_mode;

  property p_ref_missing;
    @(posedge pclk) disable iff (!presetn) $rose(synth_ref_clock) |=> !ref_clock_missing;
  endproperty
  a_ref_missing: assert property (p_ref_missing) else $error("missing flag held after edge");
  property p_ref_raise;
    @(posedge pclk) disable iff (!presetn) ref_gap_q == `SBS_REF_WIN && !$rose(synth_ref_clock)
      |=> ref_clock_missing;
  endproperty
  a_ref_raise: assert property (p_ref_raise) else $error("missing flag not raised");
  property p_squelch;
    @(posedge pclk) disable iff (!presetn) !line_signal_lost_n |=> rx_parallel_bytes == 8'h0;
  endproperty
  a_squelch: assert property (p_squelch) else $error("receive bytes not forced to zero");
  property p_cdr_ref;
    @(posedge pclk) disable iff (!presetn) cdr_tracks_ref == (!line_signal_lost_n && !ctrl_q.slave_mode);
  endproperty
  a_cdr_ref: assert property (p_cdr_ref) else $error("recovery reference choice wrong");
  property p_rx_clock_runs;
    @(posedge pclk) disable iff (!presetn || !counter_reset_n) (!line_signal_lost_n && !ctrl_q.bypass)[*8]
      |-> $changed(rx_cnt_q);
  endproperty
  a_rx_clock_runs: assert property (p_rx_clock_runs) else $error("receive clock stopped under loss");
  property p_alarm_clear;
    @(posedge pclk) disable iff (!presetn) transition_alarm_clear |=> !no_transition_alarm;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");
  property p_alarm_set;
    @(posedge pclk) disable iff (!presetn) $rose(no_transition_alarm) |-> $past(quiet_d) == `SBS_SILENCE_BITS;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm raised early");
  property p_sync_pulse;
    @(posedge pclk) disable iff (!presetn) frame_found_pulse |=> !frame_found_pulse;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("frame sync longer than one cycle");
  property p_tx_phase;
    @(posedge pclk) disable iff (!presetn) tx_byte_clock ==
      (3'(tx_cnt_q - {tx_clk_phase_sel_hi, tx_clk_phase_sel_lo, 1'b0}) < 3'd4) || $changed(tx_clk_phase_sel_lo)
      || $changed(tx_clk_phase_sel_hi) || !$past(presetn);
  endproperty
  a_tx_phase: assert property (p_tx_phase) else $error("byte clock phase wrong");
  c_sync: cover property (@(posedge pclk) disable iff (!presetn) frame_found_pulse && reframe_request);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_freq_locked));
  c_alarm: cover property (@(posedge pclk) disable iff (!presetn) $rose(no_transition_alarm));
endmodule // sbs_serdes

// [sbs_serdes_tb.sv]
// Self-checking bench of the byte serdes
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sbs_serdes_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic counter_reset_n, synth_ref_clock, rx_line_clock, rx_serial_bit, line_signal_lost_n;
  logic transition_alarm_clear, reframe_request, tx_clk_phase_sel_lo, tx_clk_phase_sel_hi;
  logic [7:0] tx_parallel_bytes, rx_parallel_bytes, line_byte;
  logic tx_byte_clock, tx_serial_bit, rx_bus_oe, rx_byte_clock, frame_found_pulse;
  logic ref_clock_missing, no_transition_alarm, rx_freq_locked, cdr_tracks_ref;
  logic ref_run, line_run, byte_taken, low_rate_select;
  logic [6:0] divs [5] = '{7'h20, 7'h10, 7'h0c, 7'h08, 7'h44};
  int num_errors, num_checks, n, m, m0, f0;
  int cyc = 0;
  int frames = 0;

  sbs_serdes #(.LOCK_WIN(2000), .RX_PER_REF(1)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_reset_n,
    .synth_ref_clock, .rx_line_clock, .rx_serial_bit, .line_signal_lost_n,
    .transition_alarm_clear, .reframe_request, .low_rate_select,
    .tx_clk_phase_sel_lo, .tx_clk_phase_sel_hi, .tx_parallel_bytes, .tx_byte_clock,
    .tx_serial_bit, .rx_parallel_bytes, .rx_bus_oe, .rx_byte_clock, .frame_found_pulse,
    .ref_clock_missing, .no_transition_alarm, .rx_freq_locked, .cdr_tracks_ref);
  sbs_far_end FAR (.pclk, .presetn, .ref_run, .line_run, .line_byte,
    .synth_ref_clock, .rx_line_clock, .rx_serial_bit, .byte_taken);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (frame_found_pulse === 1'b1) frames <= frames + 1;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hands one byte to the line; returns once its last bit is on the wire
  task send(input logic [7:0] b);
    line_byte <= b;
    do @(posedge pclk); while (byte_taken !== 1'b1);
  endtask

  // Counts ones on the serial output over two bytes
  task ones(output int r);
    r = 0;
    repeat (16) begin
      @(posedge pclk);
      r += int'(tx_serial_bit);
    end
  endtask

  // Counts level changes of the transmit or receive byte clock
  task flips(input bit tx, input int len, output int r);
    r = 0;
    pv = tx ? tx_byte_clock : rx_byte_clock;
    repeat (len) begin
      @(posedge pclk);
      if ((tx ? tx_byte_clock : rx_byte_clock) !== pv) r++;
      pv = tx ? tx_byte_clock : rx_byte_clock;
    end
  endtask

  task rise(output int r);
    r = -1;
    pv = 1'b1;
    while (r < 0) begin
      @(posedge pclk);
      if (tx_byte_clock === 1'b1 && pv === 1'b0) r = cyc % 8;
      pv = tx_byte_clock;
    end
  endtask

  task done(input string t);
    $display("Test %s ended, mismatches %0d", t, num_errors);
  endtask

  initial begin
    num_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    counter_reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    line_signal_lost_n = 1'b1;
    transition_alarm_clear = 1'b0;
    reframe_request = 1'b0;
    tx_clk_phase_sel_lo = 1'b0;
    tx_clk_phase_sel_hi = 1'b0;
    tx_parallel_bytes = 8'h01;
    ref_run = 1'b1;
    line_run = 1'b1;
    line_byte = 8'h55;
    low_rate_select = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    counter_reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[7:0], 8'h04)
    for (int s = 0; s < 5; s++) begin
      apb(1'b1, 12'h000, 32'h04 | (s << 4));
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[14:8], divs[s])
    end
    apb(1'b1, 12'h000, 32'h04);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(err, 1'b1)
    done("registers");
    for (int i = 0; i < 12000 && rx_freq_locked !== 1'b1; i++) @(posedge pclk);
    `CHK(rx_freq_locked, 1'b1)
    line_run <= 1'b0;
    for (int i = 0; i < 9000 && rx_freq_locked !== 1'b0; i++) @(posedge pclk);
    `CHK(rx_freq_locked, 1'b0)
    line_run <= 1'b1;
    done("lock");
    line_byte <= 8'h00;
    repeat (216) @(posedge pclk);
    `CHK(no_transition_alarm, 1'b0)
    repeat (80) @(posedge pclk);
    `CHK(no_transition_alarm, 1'b1)
    transition_alarm_clear <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(no_transition_alarm, 1'b0)
    transition_alarm_clear <= 1'b0;
    done("silence");
    ref_run <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK(ref_clock_missing, 1'b1)
    ref_run <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(ref_clock_missing, 1'b0)
    done("reference");
    reframe_request <= 1'b1;
    f0 = frames;
    for (int i = 0; i < 13; i++) send(8'hf6);
    for (int i = 0; i < 3; i++) send(8'h28);
    send(8'h5a);
    send(8'h00);
    `CHK(frames - f0, 1)
    `CHK(rx_parallel_bytes, 8'h5a)
    `CHK(rx_bus_oe, 1'b1)
    reframe_request <= 1'b0;
    done("framer");
    line_signal_lost_n <= 1'b0;
    line_run <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(rx_parallel_bytes, 8'h00)
    `CHK(cdr_tracks_ref, 1'b1)
    flips(1'b0, 32, n);
    `CHK(n, 8)
    apb(1'b1, 12'h000, 32'h0c);
    @(posedge pclk);
    `CHK(cdr_tracks_ref, 1'b0)
    apb(1'b1, 12'h000, 32'h04);
    line_signal_lost_n <= 1'b1;
    line_run <= 1'b1;
    done("signal loss");
    ones(n);
    `CHK(n, 2)
    for (int c = 0; c < 4; c++) begin
      tx_clk_phase_sel_hi <= c[1];
      tx_clk_phase_sel_lo <= c[0];
      repeat (24) @(posedge pclk);
      rise(m);
      if (c == 0) m0 = m;
      `CHK(m, (m0 + 2 * c) % 8)
    end
    apb(1'b1, 12'h000, 32'h06);
    ref_run <= 1'b0;
    repeat (4) @(posedge pclk);
    tx_parallel_bytes <= 8'h07;
    repeat (16) @(posedge pclk);
    ones(n);
    `CHK(n, 2)
    ref_run <= 1'b1;
    repeat (24) @(posedge pclk);
    ones(n);
    `CHK(n, 6)
    done("transmit");
    apb(1'b1, 12'h000, 32'h84);
    low_rate_select <= 1'b1;
    repeat (8) @(posedge pclk);
    flips(1'b1, 64, n);
    `CHK(n, 4)
    apb(1'b1, 12'h000, 32'h04);
    f0 = frames;
    send(8'h00);
    for (int i = 0; i < 4; i++) send(8'hf6);
    for (int i = 0; i < 3; i++) send(8'h28);
    send(8'h00);
    `CHK(frames - f0, 1)
    low_rate_select <= 1'b0;
    done("low rate");
    stop_test();
  end
endmodule // sbs_serdes_tb
